// ### hdl/tip_pkg.sv
// Constants, types and helpers shared by the transmit input port files.
// Assumes a 100 MHz core clock and a framer that drives the rails on the transmit clock.
package tip_pkg;
   localparam logic MODE_STRAP_HOST = 1'b1;
   // Core clock edges after reset before the strap synchroniser shows the pin.
   localparam logic [1:0] STRAP_AGE_RST = 2'h0;
   localparam logic [1:0] STRAP_SYNC_DEPTH = 2'h2;
   localparam logic [1:0] STRAP_AGE_DONE = 2'h3;

   // Bundle carried from the link domain, one per falling transmit clock edge.
   localparam int BUNDLE_W = 4;
   localparam int BND_A = 0;
   localparam int BND_B = 1;
   localparam int BND_RISE_A = 2;
   localparam int BND_RISE_B = 3;
   localparam logic [3:0] BUNDLE_RST = 4'h0;

   // Master clock periods without a transmit clock edge before falling back.
   localparam logic [3:0] CLK_LOSS_MCLK_CYCLES = 4'h8;
   localparam logic [3:0] LOSS_CNT_RST = 4'h0;

   // Register map, byte addresses on a 32-bit Avalon-MM slave.
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_VIOL_CNT = 4'h8;
   localparam logic [3:0] REG_LERR_CNT = 4'hC;
   localparam int CTRL_UNIPOLAR = 0;
   localparam int CTRL_PATTERN = 1;
   localparam int CTRL_LOOP_LO = 2;
   localparam int CTRL_LOOP_HI = 3;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam int STAT_MASTER = 0;
   localparam int STAT_HOST = 1;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [31:0] READ_ZERO = 32'h00000000;

   typedef enum logic [1:0] {LOOP_NONE, LOOP_LOCAL, LOOP_REMOTE, LOOP_ANALOG} tip_loop_t;
   typedef enum logic {SRC_TX, SRC_MASTER} tip_src_t;

   function automatic logic tip_rise(input logic prev, input logic cur);
      return !prev && cur;
   endfunction : tip_rise
endpackage : tip_pkg

// ### hdl/tip_sync.sv
// Two flip-flop synchroniser for asynchronous levels.
// Assumes each bit is an independent level; the first stage is read only by the second.
`timescale 1ns/100ps
`default_nettype none
module tip_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] stage1_q;
   logic [W-1:0] stage2_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stage1_q <= '0;
         stage2_q <= '0;
      end else begin
         stage1_q <= din;
         stage2_q <= stage1_q;
      end
   end

   assign dout = stage2_q;
endmodule : tip_sync
`default_nettype wire

// ### hdl/tip_link_capture.sv
// Link-side capture of the two transmit input pins on the falling transmit clock.
// Assumes the framer launches the pins from the same transmit clock.
`timescale 1ns/100ps
`default_nettype none
module tip_link_capture
   import tip_pkg::*;
(
   input wire logic txClk,
   input wire logic rstn,
   input wire logic pinA,
   input wire logic pinB,
   output logic [tip_pkg::BUNDLE_W-1:0] bundle,
   output logic evtToggle
);
   logic prevA_q;
   logic prevB_q;
   logic [BUNDLE_W-1:0] bundle_q;
   logic toggle_q;

   // The previous samples feed the request edge detection.
   always_ff @(negedge txClk or negedge rstn) begin
      if (!rstn) begin
         prevA_q <= 1'b0;
         prevB_q <= 1'b0;
      end else begin
         prevA_q <= pinA;
         prevB_q <= pinB;
      end
   end

   // The bundle is held a whole transmit clock period, so the core reads it only
   // after the toggle has crossed and the bits have long settled.
   always_ff @(negedge txClk or negedge rstn) begin
      if (!rstn) begin
         bundle_q <= BUNDLE_RST;
      end else begin
         bundle_q[BND_A] <= pinA;
         bundle_q[BND_B] <= pinB;
         bundle_q[BND_RISE_A] <= tip_rise(prevA_q, pinA);
         bundle_q[BND_RISE_B] <= tip_rise(prevB_q, pinB);
      end
   end

   always_ff @(negedge txClk or negedge rstn) begin
      if (!rstn) begin
         toggle_q <= 1'b0;
      end else begin
         toggle_q <= !toggle_q;
      end
   end

   assign bundle = bundle_q;
   assign evtToggle = toggle_q;
endmodule : tip_link_capture
`default_nettype wire

// ### hdl/tip_tx_input_port.sv
// Transmit input port top: sample selection, mode decoding and register slave.
// Assumes the framer pins, the master clock and the mode strap are asynchronous
// to core_clk, and that the transmit clock clocks the link capture.
`timescale 1ns/100ps
`default_nettype none
module tip_tx_input_port
   import tip_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic txClk,
   input wire logic masterClk,
   input wire logic txPositiveRail,
   input wire logic txNegativeRail,
   input wire logic modeStrap,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic txPos,
   output logic txNeg,
   output logic txDataValid,
   output logic logicErrLine,
   output logic logicErrLoop,
   output logic violPattern,
   output logic violData,
   output logic usingMaster,
   output logic hostMode
);
   import tip_pkg::*;

   logic [BUNDLE_W-1:0] linkBundle;
   logic linkToggle;
   logic linkToggleS;
   logic [2:0] pinS;
   logic mclkS;
   logic pinAS;
   logic pinBS;
   logic strapS;

   logic linkTogglePrev_q;
   logic mclkPrev_q;
   logic txSeen;
   logic mclkFall;

   tip_src_t src_q;
   logic [3:0] lossCnt_q;

   logic prevA_q;
   logic prevB_q;
   logic evt;
   logic [BUNDLE_W-1:0] evtBundle;

   logic [3:0] ctrl_q;
   logic unipolar;
   logic pattern;
   tip_loop_t loopSel;

   logic txPos_q;
   logic txNeg_q;
   logic txDataValid_q;
   logic logicErrLine_q;
   logic logicErrLoop_q;
   logic violPattern_q;
   logic violData_q;
   logic hostMode_q;
   logic [1:0] strapAge_q;
   logic [15:0] violCnt_q;
   logic [15:0] lerrCnt_q;
   logic [31:0] readData_q;
   logic waitReq_q;
   logic access;
   logic accept;
   logic [31:0] readMux;

   // Link domain: pins sampled on the falling transmit clock.
   tip_link_capture u_capture (
      .txClk(txClk),
      .rstn(rstn),
      .pinA(txPositiveRail),
      .pinB(txNegativeRail),
      .bundle(linkBundle),
      .evtToggle(linkToggle)
   );

   tip_sync #(.W(1)) u_sync_toggle (
      .clk(core_clk),
      .rstn(rstn),
      .din(linkToggle),
      .dout(linkToggleS)
   );

   // Master clock and pins are synchronised for the fallback sampling path.
   tip_sync #(.W(3)) u_sync_pins (
      .clk(core_clk),
      .rstn(rstn),
      .din({masterClk, txNegativeRail, txPositiveRail}),
      .dout(pinS)
   );

   tip_sync #(.W(1)) u_sync_strap (
      .clk(core_clk),
      .rstn(rstn),
      .din(modeStrap),
      .dout(strapS)
   );

   assign mclkS = pinS[2];
   assign pinBS = pinS[1];
   assign pinAS = pinS[0];

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         linkTogglePrev_q <= 1'b0;
         mclkPrev_q <= 1'b0;
      end else begin
         linkTogglePrev_q <= linkToggleS;
         mclkPrev_q <= mclkS;
      end
   end

   assign txSeen = linkToggleS != linkTogglePrev_q;
   assign mclkFall = mclkPrev_q && !mclkS;

   // Clock source selection. A transmit edge restarts the loss count, and enough
   // master clock periods without one hand sampling to the master clock.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         src_q <= SRC_TX;
         lossCnt_q <= LOSS_CNT_RST;
      end else begin
         case (src_q)
            SRC_TX: begin
               if (txSeen) begin
                  lossCnt_q <= LOSS_CNT_RST;
               end else if (mclkFall) begin
                  if (lossCnt_q == CLK_LOSS_MCLK_CYCLES - 4'h1) begin
                     src_q <= SRC_MASTER;
                     lossCnt_q <= LOSS_CNT_RST;
                  end else begin
                     lossCnt_q <= lossCnt_q + 4'h1;
                  end
               end
            end
            SRC_MASTER: begin
               if (txSeen) begin
                  src_q <= SRC_TX;
               end
            end
            default: begin
               src_q <= SRC_TX;
               lossCnt_q <= LOSS_CNT_RST;
            end
         endcase
      end
   end

   // One sampling event per falling edge of the chosen clock; the fallback path forms its
   // own rise flags against the last sample, whichever source took it.
   always_comb begin
      evtBundle = linkBundle;
      evt = 1'b0;
      if (src_q == SRC_TX) begin
         evt = txSeen;
      end else begin
         evt = mclkFall;
         evtBundle[BND_A] = pinAS;
         evtBundle[BND_B] = pinBS;
         evtBundle[BND_RISE_A] = tip_rise(prevA_q, pinAS);
         evtBundle[BND_RISE_B] = tip_rise(prevB_q, pinBS);
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         prevA_q <= 1'b0;
         prevB_q <= 1'b0;
      end else if (evt) begin
         prevA_q <= evtBundle[BND_A];
         prevB_q <= evtBundle[BND_B];
      end
   end

   assign unipolar = ctrl_q[CTRL_UNIPOLAR];
   assign pattern = ctrl_q[CTRL_PATTERN];
   assign loopSel = tip_loop_t'(ctrl_q[CTRL_LOOP_HI:CTRL_LOOP_LO]);

   // Sample outputs. In unipolar test pattern mode the shared input is the error
   // request, so no user data is presented then.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         txPos_q <= 1'b0;
         txNeg_q <= 1'b0;
         txDataValid_q <= 1'b0;
      end else begin
         txDataValid_q <= evt;
         if (evt) begin
            if (!unipolar) begin
               txPos_q <= evtBundle[BND_A];
               txNeg_q <= evtBundle[BND_B];
            end else begin
               txPos_q <= pattern ? 1'b0 : evtBundle[BND_A];
               txNeg_q <= 1'b0;
            end
         end
      end
   end

   // Error and violation requests in unipolar mode only, one pulse per rising request input.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         logicErrLine_q <= 1'b0;
         logicErrLoop_q <= 1'b0;
         violPattern_q <= 1'b0;
         violData_q <= 1'b0;
      end else begin
         logicErrLine_q <= 1'b0;
         logicErrLoop_q <= 1'b0;
         violPattern_q <= 1'b0;
         violData_q <= 1'b0;
         if (evt && unipolar) begin
            if (pattern && evtBundle[BND_RISE_A]) begin
               logicErrLine_q <= loopSel == LOOP_NONE;
               logicErrLoop_q <= loopSel != LOOP_NONE;
            end
            if (evtBundle[BND_RISE_B]) begin
               violPattern_q <= pattern;
               violData_q <= !pattern;
            end
         end
      end
   end

   // The strap is caught once, after its synchroniser has filled; catching it at the
   // first edge would take the synchroniser's reset value instead of the pin.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         hostMode_q <= 1'b0;
         strapAge_q <= STRAP_AGE_RST;
      end else if (strapAge_q != STRAP_AGE_DONE) begin
         strapAge_q <= strapAge_q + 2'h1;
         if (strapAge_q == STRAP_SYNC_DEPTH) begin
            hostMode_q <= strapS == MODE_STRAP_HOST;
         end
      end
   end

   // Counters let software see the requests that were acted on; they wrap.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         violCnt_q <= CNT_RST;
         lerrCnt_q <= CNT_RST;
      end else begin
         if (violPattern_q || violData_q) begin
            violCnt_q <= violCnt_q + 16'h0001;
         end
         if (logicErrLine_q || logicErrLoop_q) begin
            lerrCnt_q <= lerrCnt_q + 16'h0001;
         end
      end
   end

   // Avalon-MM slave with one wait state: waitrequest drops one cycle after the
   // request appears and the access completes at the edge that sees it low.
   assign access = avs_read || avs_write;
   assign accept = access && !waitReq_q;

   always_comb begin
      readMux = READ_ZERO;
      case (avs_address)
         REG_CTRL: readMux[3:0] = ctrl_q;
         REG_STATUS: begin
            readMux[STAT_MASTER] = src_q == SRC_MASTER;
            readMux[STAT_HOST] = hostMode_q;
         end
         REG_VIOL_CNT: readMux[15:0] = violCnt_q;
         REG_LERR_CNT: readMux[15:0] = lerrCnt_q;
         default: readMux = READ_ZERO;
      endcase
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         waitReq_q <= 1'b1;
         readData_q <= READ_ZERO;
      end else begin
         if (accept) begin
            waitReq_q <= 1'b1;
         end else if (access) begin
            waitReq_q <= 1'b0;
            readData_q <= readMux;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= CTRL_RST;
      end else if (accept && avs_write && avs_address == REG_CTRL) begin
         ctrl_q <= avs_writedata[3:0];
      end
   end

   assign avs_readdata = readData_q;
   assign avs_waitrequest = waitReq_q;
   assign txPos = txPos_q;
   assign txNeg = txNeg_q;
   assign txDataValid = txDataValid_q;
   assign logicErrLine = logicErrLine_q;
   assign logicErrLoop = logicErrLoop_q;
   assign violPattern = violPattern_q;
   assign violData = violData_q;
   assign usingMaster = src_q == SRC_MASTER;
   assign hostMode = hostMode_q;
endmodule : tip_tx_input_port
`default_nettype wire

// ### dv/tip_tx_input_port_sva.sv
// Checker on the transmit input port top-level ports.
// Assumes one core clock domain; bound to every instance of the top module.
`timescale 1ns/100ps
`default_nettype none
module tip_tx_input_port_sva (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic txDataValid,
   input wire logic txPos,
   input wire logic txNeg,
   input wire logic violData,
   input wire logic violPattern,
   input wire logic logicErrLine,
   input wire logic logicErrLoop,
   input wire logic modeStrap,
   input wire logic hostMode
);
   logic [2:0] settle_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // The strap passes a synchroniser first, so it is only judged once settled.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         settle_q <= 3'h0;
      end else if (settle_q != 3'h7) begin
         settle_q <= settle_q + 3'h1;
      end
   end
   sequence busStart;
      $rose(avs_read || avs_write);
   endsequence
   sequence busAnswer;
      ##[1:2] !avs_waitrequest;
   endsequence
   chk_bus_answer:
      assert property (busStart |-> busAnswer) else $error("bus answer missing");
   chk_wait_single:
      assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low too long");
   chk_wait_cause:
      assert property (!avs_waitrequest |-> avs_read || avs_write) else $error("answer alone");
   chk_valid_pulse:
      assert property (txDataValid |=> !txDataValid) else $error("strobe too long");
   chk_rail_hold:
      assert property (!txDataValid |-> $stable({txPos, txNeg})) else $error("rails moved");
   chk_viol_sample:
      assert property (violData || violPattern |-> txDataValid && !(violData && violPattern))
      else $error("violation pulse wrong");
   chk_viol_once:
      assert property (violData || violPattern |=> !(violData || violPattern))
      else $error("violation pulse too long");
   chk_lerr_sample:
      assert property (logicErrLine || logicErrLoop |-> txDataValid && !(logicErrLine && logicErrLoop))
      else $error("logic error pulse wrong");
   chk_host_strap:
      assert property (settle_q == 3'h7 |-> hostMode == modeStrap) else $error("host mode wrong");
endmodule : tip_tx_input_port_sva
bind tip_tx_input_port tip_tx_input_port_sva i_tip_tx_input_port_sva (.core_clk, .rstn,
   .avs_read, .avs_write, .avs_waitrequest, .txDataValid, .txPos, .txNeg, .violData,
   .violPattern, .logicErrLine, .logicErrLoop, .modeStrap, .hostMode);
`default_nettype wire

// ### dv/tip_framer_model.sv
// Framer model: makes the transmit clock and drives the two rail pins.
// Assumes the bench supplies the next pin values and gates the clock with run.
`timescale 1ns/100ps
`default_nettype none
module tip_framer_model (
   input wire logic run,
   input wire logic nextA,
   input wire logic nextB,
   output logic txClk,
   output logic pinA,
   output logic pinB
);
   // The clock stops low between frames, which lets the port fall back to the master clock.
   initial begin
      txClk = 1'b0;
      pinA = 1'b0;
      pinB = 1'b0;
      #37;
      forever begin
         if (run) begin
            txClk = 1'b1;
            pinA <= nextA;
            pinB <= nextB;
            #80;
            txClk = 1'b0;
            #80;
         end else begin
            #10;
         end
      end
   end
endmodule : tip_framer_model
`default_nettype wire

// ### dv/t1e1_transmit_input_port_bench.sv
// Self-checking bench for the transmit input port with a framer model.
// Assumes a 100 MHz core clock, a 160 ns transmit clock and a host-mode strap up to the second reset.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
module t1e1_transmit_input_port_bench;
   import tip_pkg::*;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic masterClk = 1'b0;
   logic mclkOn = 1'b0;
   logic run = 1'b0;
   logic nextA = 1'b0;
   logic nextB = 1'b0;
   logic track = 1'b0;
   logic strap = MODE_STRAP_HOST;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata, rd;
   logic avs_waitrequest, txClk, pinA, pinB, txPos, txNeg, txDataValid, usingMaster;
   logic logicErrLine, logicErrLoop, violPattern, violData, hostMode;
   logic [3:0] ctrl = 4'h0;
   logic [1:0] q[$];
   logic [1:0] s;
   logic pa = 1'b0;
   logic pb = 1'b0;
   logic ra, rb, uni, pat, lp;
   logic [3:0] modes[7] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hB, 4'hF, 4'h2};
   int n_errors = 0;
   int num_checks = 0;
   int seed = 32'hE82BCAF7;
   int nV = 0;
   int nL = 0;
   always #5 core_clk = ~core_clk;
   always #85 masterClk = mclkOn ? ~masterClk : 1'b0;
   tip_framer_model i_tip_framer_model (.run, .nextA, .nextB, .txClk, .pinA, .pinB);
   tip_tx_input_port i_tip_tx_input_port (.core_clk, .rstn, .txClk, .masterClk,
      .txPositiveRail(pinA), .txNegativeRail(pinB), .modeStrap(strap),
      .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
      .txPos, .txNeg, .txDataValid, .logicErrLine, .logicErrLoop, .violPattern, .violData,
      .usingMaster, .hostMode);
   always @(negedge txClk) if (track) q.push_back({pinA, pinB});
   // Reference model: every sample is paired with one strobe, in order.
   always @(posedge core_clk) begin
      if (track && txDataValid === 1'b1) begin
         `CHK(q.size() > 0, 1'b1)
         s = q.pop_front();
         uni = ctrl[CTRL_UNIPOLAR];
         pat = ctrl[CTRL_PATTERN];
         lp = ctrl[3:2] != 2'b00;
         ra = s[1] && !pa;
         rb = s[0] && !pb;
         pa = s[1];
         pb = s[0];
         `CHK(txPos, s[1] && !(uni && pat))
         `CHK(txNeg, uni ? 1'b0 : s[0])
         `CHK(violData, uni && rb && !pat)
         `CHK(violPattern, uni && rb && pat)
         `CHK(logicErrLine, uni && pat && ra && !lp)
         `CHK(logicErrLoop, uni && pat && ra && lp)
         nV += int'(uni && rb);
         nL += int'(uni && pat && ra);
      end
   end
   task automatic wrap_up;
      $display("Checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= !wr;
      avs_write <= wr;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) begin
         n_errors++;
         wrap_up();
      end
   endtask : bus
   task automatic rchk(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h00000000);
      `CHK(rd, e)
   endtask : rchk
   task automatic waitMaster(input logic v);
      int n;
      for (n = 0; n < 2000 && usingMaster !== v; n++) @(posedge core_clk);
      if (n >= 2000) begin
         n_errors++;
         wrap_up();
      end
   endtask : waitMaster
   initial begin
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      rchk(REG_CTRL, 32'h00000000);
      rchk(REG_STATUS, 32'h00000002);
      rchk(REG_VIOL_CNT, 32'h00000000);
      rchk(4'h1, 32'h00000000);
      bus(1'b1, REG_STATUS, 32'hFFFFFFFF);
      rchk(REG_STATUS, 32'h00000002);
      foreach (modes[i]) begin
         bus(1'b1, REG_CTRL, {28'($random(seed)), modes[i]});
         ctrl = modes[i];
         rchk(REG_CTRL, {28'h0000000, modes[i]});
         track <= 1'b1;
         run <= 1'b1;
         repeat (640) begin
            @(posedge core_clk);
            nextA <= 1'($random(seed));
            nextB <= 1'($random(seed));
         end
         run <= 1'b0;
         repeat (40) @(posedge core_clk);
         `CHK(q.size(), 0)
      end
      rchk(REG_VIOL_CNT, {16'h0000, 16'(nV)});
      rchk(REG_LERR_CNT, {16'h0000, 16'(nL)});
      // Fallback is checked last: the link's previous sample may be stale after it.
      track <= 1'b0;
      mclkOn <= 1'b1;
      waitMaster(1'b1);
      repeat (40) @(posedge core_clk);
      `CHK(txPos, pinA)
      `CHK(txNeg, pinB)
      rchk(REG_STATUS, 32'h00000003);
      run <= 1'b1;
      waitMaster(1'b0);
      rchk(REG_STATUS, 32'h00000002);
      // A second reset in mid-run with the strap low must bring up hardware mode.
      @(posedge core_clk);
      rstn <= 1'b0;
      strap <= 1'b0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      rchk(REG_CTRL, 32'h00000000);
      rchk(REG_STATUS, 32'h00000000);
      wrap_up();
   end
endmodule : t1e1_transmit_input_port_bench
`default_nettype wire
